// ### rtl/acc_conv_ctrl.sv
// Converter control: AHB-Lite registers, start logic, result and interrupt
// What this block does
// - Results are ten bits wide, one step is 1/1024 of full scale.
// - A result read meeting a result update returns the old value first.
// - Trigger edges are ignored while converting, done cycle included.
// - Mode or channel write at conversion end drops result and interrupt.
// - Channel writes leave the conversion-done flag untouched.
// - Standby stops the converter; software should clear run first.
// - Eight analog inputs share pins with eight general-purpose port lines.
// - Conversion time runs from sampling start to result, sampling included.
// - Writing mode with run cleared stops a conversion at once.
// - Hardware-trigger mode starts one conversion per trigger edge taken while idle.
// - Software mode repeats conversions until run clear or standby; a channel rewrite restarts the current one.
// - Result store and done request happen on the same edge.
`timescale 1ns/1ps
module acc_conv_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic compGe,
  output logic sampleOn,
  output logic [9:0] sarTap,
  output logic [2:0] analogChanSel,
  input wire logic externalTriggerIn,
  input wire logic standbyReq,
  input wire logic [7:0] sharedPortIn,
  output logic [7:0] sharedPortOut,
  output logic [7:0] sharedPortOeN,
  output logic conversionDoneIrq
);
  logic addrOk;
  logic wrPend_ff;
  logic [7:0] wrOfs_ff;
  logic [31:0] rdData_ff;
  logic [7:0] mode_ff;
  logic [2:0] chan_ff;
  logic [9:0] result_ff;
  logic irqStat_ff;
  logic irqMask_ff;
  logic [7:0] portOut_ff;
  logic [7:0] portDir_ff;
  logic [7:0] settle_ff;
  logic trigPrev_ff;
  logic modeWr;
  logic chanWr;
  logic regAbort;
  logic runOn;
  logic hwMode;
  logic trigEdge;
  logic trigTake;
  logic softStart;
  logic sarStart;
  logic sarAbort;
  logic sarBusy;
  logic sarDone;
  logic takeResult;
  logic [9:0] sarResult;

  // ==========================================================================
  // Bus front end
  // Zero wait states, so a read answers in the cycle after its address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrOk = hsel && htrans[1] && hready;

  // Data-phase write strobe for one register offset
  function automatic logic wrHit(input logic [7:0] ofs);
    return wrPend_ff && (wrOfs_ff == ofs);
  endfunction : wrHit

  // Read value of a register; unmapped offsets read zero
  function automatic logic [31:0] readMux(input logic [7:0] ofs);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (ofs == acc_pkg::OFS_MODE) begin
      v = {24'h00_0000, mode_ff};
    end else if (ofs == acc_pkg::OFS_CHAN) begin
      v = {29'h0000_0000, chan_ff};
    end else if (ofs == acc_pkg::OFS_RESULT) begin
      v = {22'h00_0000, result_ff};
    end else if (ofs == acc_pkg::OFS_IRQ_STAT) begin
      v = {31'h0000_0000, irqStat_ff};
    end else if (ofs == acc_pkg::OFS_IRQ_MASK) begin
      v = {31'h0000_0000, irqMask_ff};
    end else if (ofs == acc_pkg::OFS_STATUS) begin
      v[acc_pkg::STAT_BUSY] = sarBusy;
      v[acc_pkg::STAT_WAIT_TRIG] = hwMode && runOn && !sarBusy;
      v[acc_pkg::STAT_SETTLED] = (settle_ff == acc_pkg::SETTLE_CYC);
    end else if (ofs == acc_pkg::OFS_PORT_OUT) begin
      v = {24'h00_0000, portOut_ff};
    end else if (ofs == acc_pkg::OFS_PORT_DIR) begin
      v = {24'h00_0000, portDir_ff};
    end else if (ofs == acc_pkg::OFS_PORT_IN) begin
      v = {24'h00_0000, sharedPortIn};
    end
    return v;
  endfunction : readMux

  // Address phase capture; writes land one cycle later with hwdata
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wrPend_ff <= 1'b0;
      wrOfs_ff <= 8'h00;
    end else begin
      wrPend_ff <= addrOk && hwrite;
      wrOfs_ff <= haddr[7:0];
    end
  end

  // Read data sampled at the address edge, before any result update
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdData_ff <= 32'h0000_0000;
    end else if (addrOk && !hwrite) begin
      rdData_ff <= readMux(haddr[7:0]);
    end
  end
  assign hrdata = rdData_ff;

  // ==========================================================================
  // Control registers
  assign modeWr = wrHit(acc_pkg::OFS_MODE);
  assign chanWr = wrHit(acc_pkg::OFS_CHAN);

  // Mode and channel; reserved mode bits stay zero
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mode_ff <= acc_pkg::RST_MODE;
      chan_ff <= acc_pkg::RST_CHAN;
    end else begin
      if (modeWr) begin
        mode_ff <= hwdata[7:0] & acc_pkg::MODE_WMASK;
      end
      if (chanWr) begin
        chan_ff <= hwdata[2:0];
      end
    end
  end

  // Port latch and direction for the pins shared with the analog inputs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      portOut_ff <= acc_pkg::RST_PORT;
      portDir_ff <= acc_pkg::RST_PORT;
    end else begin
      if (wrHit(acc_pkg::OFS_PORT_OUT)) begin
        portOut_ff <= hwdata[7:0];
      end
      if (wrHit(acc_pkg::OFS_PORT_DIR)) begin
        portDir_ff <= hwdata[7:0];
      end
    end
  end

  // Settling timer after comparator enable; only reported, never enforced
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      settle_ff <= 8'h00;
    end else if (!mode_ff[acc_pkg::MODE_CMP_EN]) begin
      settle_ff <= 8'h00;
    end else if (settle_ff != acc_pkg::SETTLE_CYC) begin
      settle_ff <= settle_ff + 8'h01;
    end
  end

  // ==========================================================================
  // Start, stop and trigger logic
  assign runOn = mode_ff[acc_pkg::MODE_RUN] && !standbyReq;
  assign hwMode = mode_ff[acc_pkg::MODE_TRIG];
  assign regAbort = modeWr || chanWr;
  assign sarAbort = regAbort || !runOn;

  // Trigger pin is synchronous; edge polarity from the two select bits
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      trigPrev_ff <= 1'b0;
    end else begin
      trigPrev_ff <= externalTriggerIn;
    end
  end
  assign trigEdge = (externalTriggerIn && !trigPrev_ff && mode_ff[acc_pkg::MODE_RISE]) ||
                    (!externalTriggerIn && trigPrev_ff && mode_ff[acc_pkg::MODE_FALL]);

  // Busy covers the done cycle, so edges then are lost too
  assign trigTake = trigEdge && hwMode && runOn && !sarBusy && !regAbort;
  assign softStart = !hwMode && runOn && !sarBusy && !regAbort;
  assign sarStart = trigTake || softStart;

  acc_sar_engine u_sar (
    .mclk(mclk),
    .reset(reset),
    .start(sarStart),
    .abort(sarAbort),
    .compGe(compGe),
    .busy(sarBusy),
    .done(sarDone),
    .sampleOn(sampleOn),
    .tap(sarTap),
    .result(sarResult)
  );

  // ==========================================================================
  // Result store and interrupt
  // A colliding mode or channel write kills the completion outright
  assign takeResult = sarDone && !regAbort;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      result_ff <= acc_pkg::RST_RESULT;
    end else if (takeResult) begin
      result_ff <= sarResult;
    end
  end

  // Sticky done flag: set beats a same-cycle write-one clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irqStat_ff <= 1'b0;
      irqMask_ff <= 1'b0;
    end else begin
      irqStat_ff <= takeResult ||
                    (irqStat_ff && !(wrHit(acc_pkg::OFS_IRQ_STAT) && hwdata[acc_pkg::IRQ_DONE]));
      if (wrHit(acc_pkg::OFS_IRQ_MASK)) begin
        irqMask_ff <= hwdata[acc_pkg::IRQ_DONE];
      end
    end
  end
  assign conversionDoneIrq = irqStat_ff && irqMask_ff;

  // ==========================================================================
  // Pin sharing: the channel being converted is never driven digitally
  assign analogChanSel = chan_ff;
  assign sharedPortOut = portOut_ff;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      sharedPortOeN[i] = !(portDir_ff[i] && !(sarBusy && (chan_ff == 3'(i))));
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_endSoft;
    !hwMode && sarDone && !regAbort;
  endsequence
  sequence s_stillRun;
    runOn && !hwMode && !regAbort;
  endsequence

  result_width_a: assert property (addrOk && !hwrite && haddr[7:0] == acc_pkg::OFS_RESULT
    |=> hrdata[31:10] == 22'h00_0000)
    else $error("result read shows bits above ten");
  read_first_a: assert property (addrOk && !hwrite && haddr[7:0] == acc_pkg::OFS_RESULT
    && takeResult |=> hrdata[9:0] == $past(result_ff))
    else $error("colliding read did not get the old result");
  trig_ignore_a: assert property (hwMode && sarDone && trigEdge ##1 hwMode && !trigEdge |=> !sampleOn)
    else $error("trigger accepted during conversion");
  collide_drop_a: assert property (sarDone && regAbort |=> $stable(result_ff) && !irqStat_ff ||
    $past(irqStat_ff) && irqStat_ff && $stable(result_ff))
    else $error("result stored despite register write");
  chan_keep_a: assert property (chanWr && irqStat_ff |=> irqStat_ff)
    else $error("channel write cleared the done flag");
  standby_stop_a: assert property (standbyReq ##1 standbyReq |-> !sarBusy)
    else $error("converter running in standby");
  stop_now_a: assert property (modeWr && !hwdata[acc_pkg::MODE_RUN] |=> !sarBusy ##1 !sarBusy)
    else $error("run clear did not stop conversion");
  pin_release_a: assert property (sarBusy |-> sharedPortOeN[chan_ff])
    else $error("converting pin driven by port");
  // An edge in the idle cycle right after done is a fresh one, so only its absence is checked
  one_shot_a: assert property (hwMode && sarDone ##1 hwMode && !trigEdge |=> !sampleOn)
    else $error("hardware mode started without a fresh edge");
  soft_repeat_a: assert property (s_endSoft ##1 s_stillRun |-> sarStart)
    else $error("software mode did not restart");
  done_step_a: assert property (takeResult |=> irqStat_ff && result_ff == $past(sarResult))
    else $error("result and done flag not on the same edge");
endmodule : acc_conv_ctrl

// ### rtl/acc_pkg.sv
// Register map, field positions and timing for the converter control block
package acc_pkg;
  // ==========================================================================
  // Register byte offsets (low address byte only)
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CHAN = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PORT_OUT = 8'h18;
  localparam logic [7:0] OFS_PORT_DIR = 8'h1c;
  localparam logic [7:0] OFS_PORT_IN = 8'h20;

  // ==========================================================================
  // Mode register fields
  localparam int MODE_RUN = 7;
  localparam int MODE_TRIG = 6;
  localparam int MODE_FALL = 2;
  localparam int MODE_RISE = 1;
  localparam int MODE_CMP_EN = 0;
  localparam logic [7:0] MODE_WMASK = 8'hc7;

  // ==========================================================================
  // Status register fields and interrupt bit
  localparam int STAT_BUSY = 0;
  localparam int STAT_WAIT_TRIG = 1;
  localparam int STAT_SETTLED = 2;
  localparam int IRQ_DONE = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [2:0] RST_CHAN = 3'h0;
  localparam logic [9:0] RST_RESULT = 10'h000;
  localparam logic [7:0] RST_PORT = 8'h00;

  // ==========================================================================
  // Widths and timing at a 100 ns clock
  localparam int RES_BITS = 10;
  localparam int CLK_NS = 100;
  localparam int SETTLE_NS = 14000;
  localparam int SAMPLE_NS = 1000;
  localparam int SETTLE_CYC_I = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_CYC_I = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] SETTLE_CYC = 8'(SETTLE_CYC_I);
  localparam logic [3:0] SAMPLE_CYC = 4'(SAMPLE_CYC_I);
  localparam logic [3:0] MSB_IDX = 4'(RES_BITS - 1);
endpackage : acc_pkg

// ### rtl/acc_sar_engine.sv
// Successive approximation sequencer: sample, ten compares, result
`timescale 1ns/1ps
module acc_sar_engine (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic abort,
  input wire logic compGe,
  output logic busy,
  output logic done,
  output logic sampleOn,
  output logic [9:0] tap,
  output logic [9:0] result
);
  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_CMP, SAR_DONE} acc_sar_t;

  acc_sar_t state_ff;
  logic [3:0] count_ff;
  logic [9:0] sarBits_ff;
  logic [9:0] result_ff;

  // ==========================================================================
  // Sequencer; abort wins over everything so a stop is immediate
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_ff <= SAR_IDLE;
      count_ff <= 4'h0;
      sarBits_ff <= 10'h000;
      result_ff <= acc_pkg::RST_RESULT;
    end else if (abort) begin
      state_ff <= SAR_IDLE;
    end else begin
      case (state_ff)
        SAR_IDLE: begin
          if (start) begin
            state_ff <= SAR_SAMPLE;
            count_ff <= acc_pkg::SAMPLE_CYC - 4'h1;
          end
        end
        SAR_SAMPLE: begin
          if (count_ff == 4'h0) begin
            state_ff <= SAR_CMP;
            count_ff <= acc_pkg::MSB_IDX;
            sarBits_ff <= 10'h200;
          end else begin
            count_ff <= count_ff - 4'h1;
          end
        end
        SAR_CMP: begin
          sarBits_ff[count_ff] <= compGe;
          if (count_ff == 4'h0) begin
            result_ff <= {sarBits_ff[9:1], compGe};
            state_ff <= SAR_DONE;
          end else begin
            sarBits_ff[count_ff - 4'h1] <= 1'b1;
            count_ff <= count_ff - 4'h1;
          end
        end
        default: begin
          state_ff <= SAR_IDLE;
        end
      endcase
    end
  end

  // Busy spans sampling through the done cycle
  assign busy = (state_ff != SAR_IDLE);
  assign done = (state_ff == SAR_DONE);
  assign sampleOn = (state_ff == SAR_SAMPLE);
  assign tap = sarBits_ff;
  assign result = result_ff;

  sample_in_busy_a: assert property (@(posedge mclk) disable iff (reset)
    start && !busy && !abort |=> sampleOn && busy)
    else $error("conversion did not open with sampling");
endmodule : acc_sar_engine

// ### test/acc_conv_ctrl_test.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
module acc_conv_ctrl_test;
  // ====================
  // Stimulus and wiring
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic externalTriggerIn = 1'b0;
  logic standbyReq = 1'b0;
  logic [7:0] sharedPortIn = 8'h3c;
  logic [9:0] vin = 10'h0;
  logic hready, hresp, sampleOn, conversionDoneIrq, compGe;
  logic [31:0] hrdata;
  logic [9:0] sarTap;
  logic [2:0] analogChanSel;
  logic [7:0] sharedPortOut, sharedPortOeN;
  logic [31:0] q;
  int fails = 0;
  int testsRun = 0;

  // Clock at 100 ns
  always #50 mclk = ~mclk;

  // Ideal comparator, so a clean conversion must return vin exactly
  assign compGe = (vin >= sarTap);

  // Zero-wait slave: its own ready is the bus ready
  acc_conv_ctrl dut (
    .mclk, .reset, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
    .hreadyout(hready), .hresp, .compGe, .sampleOn, .sarTap, .analogChanSel, .externalTriggerIn,
    .standbyReq, .sharedPortIn, .sharedPortOut, .sharedPortOeN, .conversionDoneIrq
  );

  // ====================
  // Tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // Single transfer; read data taken at the edge that ends the data phase
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
    @(negedge mclk);
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task rc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rc

  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // Park in the first sampling cycle of the next window to open, so later delays count from it
  task sync;
    @(posedge sampleOn);
    @(negedge mclk);
  endtask : sync

  task final_report;
    if (fails == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // ====================
  // Test sequence
  initial begin
    cyc(8);
    @(posedge mclk) reset <= 1'b0;
    // Idle port lines and an unmapped offset
    rc(acc_pkg::OFS_RESULT, 32'h0);
    rc(8'h24, 32'h0);
    chk(32'(hresp), 32'h0);
    chk(32'(hready), 32'h1);
    wr(acc_pkg::OFS_PORT_DIR, 32'h0f);
    wr(acc_pkg::OFS_PORT_OUT, 32'ha5);
    rc(acc_pkg::OFS_PORT_IN, 32'h3c);
    chk(32'(sharedPortOut), 32'ha5);
    chk(32'(sharedPortOeN), 32'hf0);
    // Comparator enable, then the settling wait before running
    wr(acc_pkg::OFS_IRQ_MASK, 32'h1);
    wr(acc_pkg::OFS_MODE, 32'h01);
    cyc(142);
    rc(acc_pkg::OFS_STATUS, 32'h4);
    wr(acc_pkg::OFS_CHAN, 32'h2);
    @(posedge mclk) vin <= 10'h2b6;
    wr(acc_pkg::OFS_MODE, 32'h81);
    // Sampling window, first trial and a read meeting the update
    sync;
    chk(32'(sharedPortOeN), 32'hf4);
    chk(32'(analogChanSel), 32'h2);
    cyc(9);
    chk(32'(sampleOn), 32'h1);
    cyc(1);
    chk(32'(sampleOn), 32'h0);
    chk(32'(sarTap), 32'h200);
    cyc(9);
    rc(acc_pkg::OFS_RESULT, 32'h0);
    rc(acc_pkg::OFS_RESULT, 32'h2b6);
    rc(acc_pkg::OFS_IRQ_STAT, 32'h1);
    chk(32'(conversionDoneIrq), 32'h1);
    wr(acc_pkg::OFS_IRQ_MASK, 32'h0);
    chk(32'(conversionDoneIrq), 32'h0);
    wr(acc_pkg::OFS_IRQ_MASK, 32'h1);
    wr(acc_pkg::OFS_CHAN, 32'h2);
    rc(acc_pkg::OFS_IRQ_STAT, 32'h1);
    chk(32'(conversionDoneIrq), 32'h1);
    // Software mode keeps converting on its own
    wr(acc_pkg::OFS_IRQ_STAT, 32'h1);
    @(posedge mclk) vin <= 10'h155;
    cyc(60);
    rc(acc_pkg::OFS_RESULT, 32'h155);
    rc(acc_pkg::OFS_IRQ_STAT, 32'h1);
    // Channel write landing on the completion edge
    sync;
    @(posedge mclk) vin <= 10'h0aa;
    wr(acc_pkg::OFS_IRQ_STAT, 32'h1);
    cyc(14);
    wr(acc_pkg::OFS_CHAN, 32'h2);
    rc(acc_pkg::OFS_RESULT, 32'h155);
    rc(acc_pkg::OFS_IRQ_STAT, 32'h0);
    // Run cleared in mid-conversion
    sync;
    @(posedge mclk) vin <= 10'h3ff;
    wr(acc_pkg::OFS_IRQ_STAT, 32'h1);
    wr(acc_pkg::OFS_MODE, 32'h01);
    cyc(40);
    rc(acc_pkg::OFS_RESULT, 32'h0aa);
    rc(acc_pkg::OFS_IRQ_STAT, 32'h0);
    // Hardware start; a rising edge in the done cycle must be lost
    wr(acc_pkg::OFS_MODE, 32'hc3);
    rc(acc_pkg::OFS_STATUS, 32'h6);
    @(posedge mclk) externalTriggerIn <= 1'b1;
    sync;
    @(posedge mclk) externalTriggerIn <= 1'b0;
    cyc(19);
    @(posedge mclk) externalTriggerIn <= 1'b1;
    @(posedge mclk) vin <= 10'h001;
    cyc(40);
    rc(acc_pkg::OFS_RESULT, 32'h3ff);
    @(posedge mclk) externalTriggerIn <= 1'b0;
    cyc(3);
    @(posedge mclk) externalTriggerIn <= 1'b1;
    cyc(40);
    rc(acc_pkg::OFS_RESULT, 32'h001);
    @(posedge mclk) vin <= 10'h100;
    cyc(40);
    rc(acc_pkg::OFS_RESULT, 32'h001);
    wr(acc_pkg::OFS_MODE, 32'hc5);
    @(posedge mclk) externalTriggerIn <= 1'b0;
    cyc(40);
    rc(acc_pkg::OFS_RESULT, 32'h100);
    // Standby holds the converter still even with run set
    @(posedge mclk) standbyReq <= 1'b1;
    @(posedge mclk) vin <= 10'h2aa;
    wr(acc_pkg::OFS_MODE, 32'h81);
    cyc(40);
    rc(acc_pkg::OFS_RESULT, 32'h100);
    chk(32'(sampleOn), 32'h0);
    @(posedge mclk) standbyReq <= 1'b0;
    cyc(40);
    rc(acc_pkg::OFS_RESULT, 32'h2aa);
    final_report();
  end

  // Watchdog, far beyond the expected run of about 700 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    final_report();
  end
endmodule : acc_conv_ctrl_test
